// ===== ddc_defines.svh
// Constants for the rank command front end
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
// Read latency range, in clock cycles
`define DDC_CL_MIN 5'h0e
`define DDC_CL_MAX 5'h16
// Beats of a full and a chopped burst
`define DDC_LEN_BL8 4'h8
`define DDC_LEN_BC4 4'h4
// Read inversion when more zeros than this in a byte
`define DDC_DBI_LIMIT 4'h4
// Open-bank map after reset
`define DDC_BANK_RST 16'h0000
// Address bit positions with extra meaning
`define DDC_A_AP 10
`define DDC_A_BC 12
`endif

// ===== ddc_pkg.sv
// Types for the rank command front end
package ddc_pkg;
   typedef enum logic [3:0] {
      DDC_CMD_NONE, DDC_CMD_ACT, DDC_CMD_MRS, DDC_CMD_REF, DDC_CMD_PRE,
      DDC_CMD_RFU, DDC_CMD_WR, DDC_CMD_RD, DDC_CMD_ZQC, DDC_CMD_NOP,
      DDC_CMD_SRE
   } ddc_cmd_t;
   typedef enum logic [1:0] {
      DDC_PWR_ON, DDC_PWR_PPD, DDC_PWR_APD, DDC_PWR_SREF
   } ddc_pwr_t;
endpackage : ddc_pkg

// ===== ddc_front.sv
// Command decode, power state, termination and data mask path of one rank
// Function
// - Sample all address and control pins on the rising clock edge.
// - CKE high keeps clocks, buffers, drivers on; CKE low stops clocks and drivers.
// - CKE low: idle gives precharge power-down or self-refresh; open row active.
// - Self-refresh exit on CKE rise is seen without the clock.
// - Power-down keeps clock, ODT, CKE buffers; self-refresh keeps only CKE.
// - Commands with chip select high are ignored.
// - Chip select is part of the command and selects this rank.
// - Registered ODT high enables termination, plus TDQS when enabled.
// - ODT input is ignored when nominal termination is disabled.
// - ACT_n low with chip select is activate; RAS/CAS/WE become A16-A14.
// - ACT_n high: RAS/CAS/WE form read, write and other commands.
// - Write beats with mask sampled low are not stored.
// - Mode register 5 picks mask or inversion on the shared pin.
// - On x8 the TDQS enable bit picks mask pin or termination strobe.
// - Inversion flag low means the byte is inverted, reads and writes.
// - Bank group bits pick the group; x16 uses only BG0.
// - On mode register set, BG0 and bank address pick the register.
// - Each read or write chooses full or chopped burst.
// - Read latency programmable from 14 to 22 cycles.
// - Reset puts all internal state into a known condition.
// - A12 high on read or write is full burst, low chopped.
// - A10 requests auto-precharge, or all-bank precharge on precharge.
`timescale 1ns/10ps
`include "ddc_defines.svh"
module ddc_front
   import ddc_pkg::*;
#(
   parameter int CL_MAX = 22
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_cke,
   input wire logic i_cs_n,
   input wire logic i_act_n,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire logic [1:0] i_bg,
   input wire logic [1:0] i_ba,
   input wire logic [13:0] i_addr,
   input wire logic i_odt,
   input wire logic i_x16,
   input wire logic i_rtt_nom_en,
   input wire logic i_tdqs_en,
   input wire logic i_mr5_dm_en,
   input wire logic i_mr5_wdbi_en,
   input wire logic i_mr5_rdbi_en,
   input wire logic [4:0] i_cl,
   input wire logic i_wr_beat,
   input wire logic [7:0] i_wr_dq,
   input wire logic i_dm_dbi_n,
   input wire logic [7:0] i_rd_core,
   output ddc_cmd_t o_cmd,
   output logic o_cmd_valid,
   output logic [1:0] o_bg,
   output logic [1:0] o_ba,
   output logic [16:0] o_row,
   output logic [9:0] o_col,
   output logic o_auto_pre,
   output logic o_burst_chop,
   output logic o_pre_all,
   output logic [2:0] o_mr_sel,
   output logic [15:0] o_bank_open,
   output ddc_pwr_t o_pwr_state,
   output logic o_int_clk_en,
   output logic o_drv_en,
   output logic o_cmd_buf_en,
   output logic o_ck_buf_en,
   output logic o_odt_buf_en,
   output logic o_sr_exit,
   output logic o_odt_term,
   output logic o_tdqs_term,
   output logic o_wr_store,
   output logic [7:0] o_wr_data,
   output logic o_rd_valid,
   output logic [7:0] o_rd_dq,
   output logic o_rd_dbi_n
);

   // ==========================================================
   // Functions
   function automatic ddc_cmd_t ddc_decode(input logic act_n, input logic [2:0] rcw);
      ddc_cmd_t c;
      c = DDC_CMD_NONE;
      if (!act_n)
         c = DDC_CMD_ACT;
      else
      begin
         case (rcw)
            3'h0: c = DDC_CMD_MRS;
            3'h1: c = DDC_CMD_REF;
            3'h2: c = DDC_CMD_PRE;
            3'h3: c = DDC_CMD_RFU;
            3'h4: c = DDC_CMD_WR;
            3'h5: c = DDC_CMD_RD;
            3'h6: c = DDC_CMD_ZQC;
            default: c = DDC_CMD_NOP;
         endcase
      end
      return c;
   endfunction : ddc_decode

   function automatic logic [3:0] ddc_bank(input logic x16, input logic [1:0] bg,
                                           input logic [1:0] ba);
      return {bg[1] & ~x16, bg[0], ba};
   endfunction : ddc_bank

   function automatic logic [3:0] ddc_zeros(input logic [7:0] d);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
         n = n + {3'h0, ~d[i]};
      return n;
   endfunction : ddc_zeros

   // ==========================================================
   // Reset release
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // ==========================================================
   // Command decode
   ddc_pwr_t pwr_reg;
   ddc_pwr_t pwr_next;
   logic cke_reg;
   logic [15:0] bank_open_reg;
   ddc_cmd_t cmd_dec;
   logic cmd_ok;
   logic cke_fall;
   logic sre_go;
   logic rd_go;
   logic wr_go;
   logic [3:0] bank_idx;

   assign cmd_dec = ddc_decode(i_act_n, {i_ras_n, i_cas_n, i_we_n});
   assign cke_fall = cke_reg & ~i_cke;
   // Commands need CKE high on this and the previous edge
   assign cmd_ok = (pwr_reg == DDC_PWR_ON) && cke_reg && i_cke && !i_cs_n;
   assign sre_go = (pwr_reg == DDC_PWR_ON) && cke_fall && !i_cs_n && cmd_dec == DDC_CMD_REF;
   assign rd_go = cmd_ok && cmd_dec == DDC_CMD_RD;
   assign wr_go = cmd_ok && cmd_dec == DDC_CMD_WR;
   assign bank_idx = ddc_bank(i_x16, i_bg, i_ba);

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_cmd <= DDC_CMD_NONE;
         o_cmd_valid <= 1'b0;
         o_bg <= 2'h0;
         o_ba <= 2'h0;
         o_row <= 17'h0;
         o_col <= 10'h0;
         o_auto_pre <= 1'b0;
         o_burst_chop <= 1'b0;
         o_pre_all <= 1'b0;
         o_mr_sel <= 3'h0;
      end
      else
      begin
         // Unsupported and empty encodings stay invisible
         o_cmd_valid <= sre_go || (cmd_ok && cmd_dec != DDC_CMD_RFU
                        && cmd_dec != DDC_CMD_NOP);
         o_cmd <= sre_go ? DDC_CMD_SRE : cmd_dec;
         o_bg <= {i_bg[1] & ~i_x16, i_bg[0]};
         o_ba <= i_ba;
         o_row <= {i_ras_n, i_cas_n, i_we_n, i_addr};
         o_col <= i_addr[9:0];
         o_auto_pre <= i_addr[`DDC_A_AP] && (rd_go || wr_go);
         o_pre_all <= i_addr[`DDC_A_AP] && cmd_ok && cmd_dec == DDC_CMD_PRE;
         o_burst_chop <= !i_addr[`DDC_A_BC] && (rd_go || wr_go);
         o_mr_sel <= {i_bg[0], i_ba};
      end
   end

   // ==========================================================
   // Open-bank tracking
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
         bank_open_reg <= `DDC_BANK_RST;
      else if (cmd_ok && cmd_dec == DDC_CMD_ACT)
         bank_open_reg[bank_idx] <= 1'b1;
      else if (cmd_ok && cmd_dec == DDC_CMD_PRE && i_addr[`DDC_A_AP])
         bank_open_reg <= `DDC_BANK_RST;
      else if ((cmd_ok && cmd_dec == DDC_CMD_PRE)
               || ((rd_go || wr_go) && i_addr[`DDC_A_AP]))
         bank_open_reg[bank_idx] <= 1'b0;
   end
   assign o_bank_open = bank_open_reg;

   // ==========================================================
   // Power state
   always_comb
   begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         DDC_PWR_ON:
            if (sre_go)
               pwr_next = DDC_PWR_SREF;
            else if (cke_fall)
               pwr_next = (|bank_open_reg) ? DDC_PWR_APD : DDC_PWR_PPD;
         DDC_PWR_PPD, DDC_PWR_APD:
            if (i_cke)
               pwr_next = DDC_PWR_ON;
         DDC_PWR_SREF:
            if (i_cke)
               pwr_next = DDC_PWR_ON;
         default:
            pwr_next = DDC_PWR_ON;
      endcase
   end

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr_reg <= DDC_PWR_ON;
         cke_reg <= 1'b0;
      end
      else
      begin
         pwr_reg <= pwr_next;
         cke_reg <= i_cke;
      end
   end

   assign o_pwr_state = pwr_reg;
   assign o_int_clk_en = rst_n && i_cke;
   assign o_drv_en = rst_n && i_cke;
   assign o_cmd_buf_en = (pwr_reg == DDC_PWR_ON);
   assign o_ck_buf_en = (pwr_reg != DDC_PWR_SREF);
   assign o_odt_buf_en = (pwr_reg != DDC_PWR_SREF);
   // Combinational so the wake is seen while the clock is stopped
   assign o_sr_exit = (pwr_reg == DDC_PWR_SREF) && i_cke;

   // ==========================================================
   // Termination
   logic tdqs_on;
   assign tdqs_on = i_tdqs_en && !i_x16;

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_odt_term <= 1'b0;
         o_tdqs_term <= 1'b0;
      end
      else
      begin
         o_odt_term <= i_odt && i_rtt_nom_en && o_odt_buf_en;
         o_tdqs_term <= i_odt && i_rtt_nom_en && o_odt_buf_en && tdqs_on;
      end
   end

   // ==========================================================
   // Write data path
   logic [3:0] wr_left_reg;
   logic dm_mode;
   logic wdbi_mode;
   logic wr_take;

   // Mask wins over inversion if both are set; TDQS disables both
   assign dm_mode = i_mr5_dm_en && !tdqs_on;
   assign wdbi_mode = i_mr5_wdbi_en && !i_mr5_dm_en && !tdqs_on;
   assign wr_take = i_wr_beat && wr_left_reg != 4'h0;

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
         wr_left_reg <= 4'h0;
      else if (wr_go)
         wr_left_reg <= i_addr[`DDC_A_BC] ? `DDC_LEN_BL8 : `DDC_LEN_BC4;
      else if (wr_take)
         wr_left_reg <= wr_left_reg - 4'h1;
   end

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_wr_store <= 1'b0;
         o_wr_data <= 8'h0;
      end
      else
      begin
         o_wr_store <= wr_take && !(dm_mode && !i_dm_dbi_n);
         o_wr_data <= (wdbi_mode && !i_dm_dbi_n) ? ~i_wr_dq : i_wr_dq;
      end
   end

   // ==========================================================
   // Read latency and data
   logic [CL_MAX-1:0] rd_pipe_reg;
   logic [CL_MAX-1:0] bc_pipe_reg;
   logic [4:0] cl_eff;
   logic [3:0] rd_left_reg;
   logic rd_start;
   logic rd_beat;
   logic rdbi_inv;

   // Out-of-range latency settings are clamped to the legal range
   assign cl_eff = (i_cl < `DDC_CL_MIN) ? `DDC_CL_MIN :
                   (i_cl > `DDC_CL_MAX) ? `DDC_CL_MAX : i_cl;
   assign rd_start = rd_pipe_reg[cl_eff - 5'h1];
   assign rd_beat = rd_start || rd_left_reg > 4'h1;
   assign rdbi_inv = i_mr5_rdbi_en && !tdqs_on && ddc_zeros(i_rd_core) > `DDC_DBI_LIMIT;

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_pipe_reg <= '0;
         bc_pipe_reg <= '0;
         rd_left_reg <= 4'h0;
      end
      else
      begin
         rd_pipe_reg <= {rd_pipe_reg[CL_MAX-2:0], rd_go};
         bc_pipe_reg <= {bc_pipe_reg[CL_MAX-2:0], rd_go && !i_addr[`DDC_A_BC]};
         if (rd_start)
            rd_left_reg <= bc_pipe_reg[cl_eff - 5'h1] ? `DDC_LEN_BC4 : `DDC_LEN_BL8;
         else if (rd_left_reg != 4'h0)
            rd_left_reg <= rd_left_reg - 4'h1;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_rd_valid <= 1'b0;
         o_rd_dq <= 8'h0;
         o_rd_dbi_n <= 1'b1;
      end
      else
      begin
         o_rd_valid <= rd_beat;
         o_rd_dq <= rdbi_inv ? ~i_rd_core : i_rd_core;
         o_rd_dbi_n <= !rdbi_inv;
      end
   end

   // ==========================================================
   // Checks
   a_cs_mask: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_cs_n |=> !o_cmd_valid) else $error("command taken with chip select high");
   a_act_rows: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (cmd_ok && !i_act_n) |=> o_cmd == DDC_CMD_ACT && o_cmd_valid
      && o_row[16] == $past(i_ras_n) && o_row[15] == $past(i_cas_n)
      && o_row[14] == $past(i_we_n))
      else $error("activate decode wrong");
   a_rd_decode: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (cmd_ok && i_act_n && i_ras_n && !i_cas_n && i_we_n) |=> o_cmd == DDC_CMD_RD)
      else $error("read decode wrong");
   a_rd_min_lat: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (rd_go && cl_eff == `DDC_CL_MIN) |-> ##15 o_rd_valid) else $error("read latency 14 missed");
   a_rd_max_lat: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (rd_go && cl_eff == `DDC_CL_MAX) |-> ##23 o_rd_valid) else $error("read latency 22 missed");
   a_sref_entry: assert property (@(posedge i_mclk) disable iff (!rst_n)
      sre_go |=> pwr_reg == DDC_PWR_SREF ##1 (pwr_reg == DDC_PWR_SREF || $past(i_cke)))
      else $error("self-refresh not entered");
   a_apd_entry: assert property (@(posedge i_mclk) disable iff (!rst_n)
      ((pwr_reg == DDC_PWR_ON) && cke_fall && i_cs_n && |bank_open_reg)
      |=> pwr_reg == DDC_PWR_APD && !o_cmd_buf_en && o_ck_buf_en)
      else $error("active power-down not entered");
   a_dm_block: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (wr_take && dm_mode && !i_dm_dbi_n) |=> !o_wr_store) else $error("masked beat stored");
   a_odt_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
      !i_rtt_nom_en |=> !o_odt_term && !o_tdqs_term) else $error("ODT used while disabled");
   a_wr_invert: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (wr_take && wdbi_mode && !i_dm_dbi_n) |=> o_wr_store && o_wr_data == ~$past(i_wr_dq))
      else $error("write inversion wrong");
   a_pre_all: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (cmd_ok && cmd_dec == DDC_CMD_PRE && i_addr[`DDC_A_AP])
      |=> bank_open_reg == `DDC_BANK_RST && o_pre_all)
      else $error("precharge all left a bank open");
   a_chop_len: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (wr_go && !i_addr[`DDC_A_BC]) |=> wr_left_reg == `DDC_LEN_BC4 && o_burst_chop)
      else $error("chopped write length wrong");
endmodule : ddc_front

// ===== ddc_host.sv
// Host controller model driving the rank command pins
`timescale 1ns/10ps
module ddc_host
(
   input wire logic i_mclk,
   output logic o_cke,
   output logic o_cs_n,
   output logic o_act_n,
   output logic [2:0] o_rcw,
   output logic [1:0] o_bg,
   output logic [1:0] o_ba,
   output logic [13:0] o_addr
);
   // ==========================================================
   // Pin drive
   initial
   begin
      o_cke = 1'b1;
      o_cs_n = 1'b1;
      o_act_n = 1'b1;
      o_rcw = 3'h7;
      o_bg = 2'h0;
      o_ba = 2'h0;
      o_addr = 14'h0000;
   end

   // One command slot; CKE keeps the given level afterwards
   task automatic issue(input logic cke, cs_n, act_n, input logic [2:0] rcw,
      input logic [1:0] bg, ba, input logic [13:0] addr);
      @(posedge i_mclk);
      o_cke <= cke;
      o_cs_n <= cs_n;
      o_act_n <= act_n;
      o_rcw <= rcw;
      o_bg <= bg;
      o_ba <= ba;
      o_addr <= addr;
      @(posedge i_mclk);
      // Deselected lines other than bank group and bank do not keep their last value
      o_cs_n <= 1'b1;
      o_act_n <= ~act_n;
      o_rcw <= ~rcw;
      o_addr <= ~addr;
   endtask : issue

   task automatic set_cke(input logic cke);
      @(posedge i_mclk);
      o_cke <= cke;
   endtask : set_cke

   // Refresh slot; a controller spreads 8192 of these over each retention period
   task automatic refresh;
      issue(1'b1, 1'b0, 1'b1, 3'h1, 2'h0, 2'h0, 14'h0000);
   endtask : refresh
endmodule : ddc_host

// ===== ddc_front_bench.sv
// Self-checking bench for the rank command front end
`timescale 1ns/10ps
module ddc_front_bench import ddc_pkg::*;;
   typedef struct packed {
      logic cs_n;
      logic act_n;
      logic [2:0] rcw;
      logic vld;
      ddc_cmd_t cmd;
   } ddc_row_t;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, i_odt = 1'b0, i_x16 = 1'b0;
   logic i_rtt_nom_en = 1'b1, i_tdqs_en = 1'b0, i_mr5_dm_en = 1'b1;
   logic i_mr5_wdbi_en = 1'b0, i_mr5_rdbi_en = 1'b1, i_wr_beat = 1'b0;
   logic i_dm_dbi_n = 1'b1;
   logic [4:0] i_cl = 5'h0e;
   logic [7:0] i_wr_dq = 8'h00, i_rd_core = 8'h00;
   logic i_cke, i_cs_n, i_act_n, i_ras_n, i_cas_n, i_we_n;
   logic [2:0] rcw;
   logic [1:0] i_bg, i_ba, o_bg, o_ba;
   logic [13:0] i_addr;
   ddc_cmd_t o_cmd;
   ddc_pwr_t o_pwr_state;
   logic [16:0] o_row;
   logic [2:0] o_mr_sel;
   logic [15:0] o_bank_open;
   logic [7:0] o_wr_data, o_rd_dq;
   logic o_cmd_valid, o_pre_all, o_int_clk_en, o_drv_en, o_cmd_buf_en, o_ck_buf_en;
   logic o_odt_buf_en, o_sr_exit, o_odt_term, o_tdqs_term, o_wr_store, o_rd_valid;
   logic o_rd_dbi_n;
   logic [9:0] o_col;
   logic o_auto_pre, o_burst_chop;
   ddc_row_t rows [10];
   int miscompares = 0, comparisons = 0, cycles = 0, len, lat;

   assign {i_ras_n, i_cas_n, i_we_n} = rcw;
   ddc_front ddc_front_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cke(i_cke),
      .i_cs_n(i_cs_n), .i_act_n(i_act_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n),
      .i_we_n(i_we_n), .i_bg(i_bg), .i_ba(i_ba), .i_addr(i_addr), .i_odt(i_odt),
      .i_x16(i_x16), .i_rtt_nom_en(i_rtt_nom_en), .i_tdqs_en(i_tdqs_en),
      .i_mr5_dm_en(i_mr5_dm_en), .i_mr5_wdbi_en(i_mr5_wdbi_en),
      .i_mr5_rdbi_en(i_mr5_rdbi_en), .i_cl(i_cl), .i_wr_beat(i_wr_beat),
      .i_wr_dq(i_wr_dq), .i_dm_dbi_n(i_dm_dbi_n), .i_rd_core(i_rd_core),
      .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid), .o_bg(o_bg), .o_ba(o_ba),
      .o_row(o_row), .o_col(o_col), .o_auto_pre(o_auto_pre),
      .o_burst_chop(o_burst_chop), .o_pre_all(o_pre_all), .o_mr_sel(o_mr_sel),
      .o_bank_open(o_bank_open), .o_pwr_state(o_pwr_state), .o_int_clk_en(o_int_clk_en),
      .o_drv_en(o_drv_en), .o_cmd_buf_en(o_cmd_buf_en), .o_ck_buf_en(o_ck_buf_en),
      .o_odt_buf_en(o_odt_buf_en), .o_sr_exit(o_sr_exit), .o_odt_term(o_odt_term),
      .o_tdqs_term(o_tdqs_term), .o_wr_store(o_wr_store), .o_wr_data(o_wr_data),
      .o_rd_valid(o_rd_valid), .o_rd_dq(o_rd_dq), .o_rd_dbi_n(o_rd_dbi_n));
   ddc_host ddc_host_inst (.i_mclk(i_mclk), .o_cke(i_cke), .o_cs_n(i_cs_n),
      .o_act_n(i_act_n), .o_rcw(rcw), .o_bg(i_bg), .o_ba(i_ba), .o_addr(i_addr));

   // ==========================================================
   // Clock, timeout and shared tasks
   initial
   begin
      forever #25 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         miscompares++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : tick

   task automatic cmd(input logic cke, cs_n, act_n, input logic [2:0] c,
      input logic [1:0] bg, ba, input logic [13:0] addr);
      ddc_host_inst.issue(cke, cs_n, act_n, c, bg, ba, addr);
      #1;
   endtask : cmd

   task automatic beat(input logic [7:0] dq, input logic pin, st, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr_beat <= 1'b1;
      i_wr_dq <= dq;
      i_dm_dbi_n <= pin;
      @(posedge i_mclk);
      i_wr_beat <= 1'b0;
      #1;
      chk(o_wr_store, st);
      if (st)
         chk(o_wr_data, d);
   endtask : beat

   task automatic complete_run;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   // ==========================================================
   // Test sequence
   initial
   begin
      rows = '{'{1'b0, 1'b0, 3'h0, 1'b1, DDC_CMD_ACT}, '{1'b0, 1'b1, 3'h0, 1'b1, DDC_CMD_MRS},
         '{1'b0, 1'b1, 3'h1, 1'b1, DDC_CMD_REF}, '{1'b0, 1'b1, 3'h2, 1'b1, DDC_CMD_PRE},
         '{1'b0, 1'b1, 3'h3, 1'b0, DDC_CMD_RFU}, '{1'b0, 1'b1, 3'h4, 1'b1, DDC_CMD_WR},
         '{1'b0, 1'b1, 3'h5, 1'b1, DDC_CMD_RD}, '{1'b0, 1'b1, 3'h6, 1'b1, DDC_CMD_ZQC},
         '{1'b0, 1'b1, 3'h7, 1'b0, DDC_CMD_NOP}, '{1'b1, 1'b0, 3'h0, 1'b0, DDC_CMD_ACT}};
      tick(4);
      chk(o_pwr_state, DDC_PWR_ON);
      chk({o_cmd_valid, o_bank_open, o_rd_dbi_n, o_int_clk_en}, 19'h00002);
      @(posedge i_mclk);
      i_rst_n <= 1'b1;
      tick(2);
      $display("reset test done");
      for (int k = 0; k < 10; k++)
      begin
         cmd(1'b1, rows[k].cs_n, rows[k].act_n, rows[k].rcw, 2'h0, 2'h0, 14'h0000);
         chk(o_cmd_valid, rows[k].vld);
         if (rows[k].vld)
            chk(o_cmd, rows[k].cmd);
      end
      $display("command table done");
      cmd(1'b1, 1'b0, 1'b1, 3'h0, 2'h1, 2'h2, 14'h0000);
      chk(o_mr_sel, 3'h6);
      cmd(1'b1, 1'b0, 1'b0, 3'h5, 2'h2, 2'h1, 14'h1234);
      chk({o_row, o_bg, o_ba}, 21'h152349);
      chk(o_bank_open, 16'h0200);
      cmd(1'b0, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 14'h0000);
      tick(1);
      chk(o_pwr_state, DDC_PWR_APD);
      chk({o_int_clk_en, o_drv_en, o_cmd_buf_en, o_ck_buf_en, o_odt_buf_en}, 5'h03);
      cmd(1'b1, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 14'h0000);
      tick(1);
      chk(o_pwr_state, DDC_PWR_ON);
      cmd(1'b1, 1'b0, 1'b1, 3'h2, 2'h0, 2'h0, 14'h0400);
      chk({o_pre_all, o_bank_open}, 17'h10000);
      cmd(1'b0, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 14'h0000);
      tick(1);
      chk(o_pwr_state, DDC_PWR_PPD);
      cmd(1'b1, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 14'h0000);
      cmd(1'b0, 1'b0, 1'b1, 3'h1, 2'h0, 2'h0, 14'h0000);
      chk({o_cmd_valid, o_cmd}, {1'b1, DDC_CMD_SRE});
      tick(1);
      chk(o_pwr_state, DDC_PWR_SREF);
      chk({o_cmd_buf_en, o_ck_buf_en, o_odt_buf_en}, 3'h0);
      ddc_host_inst.set_cke(1'b1);
      #1;
      chk(o_sr_exit, 1'b1);
      tick(3);
      chk(o_pwr_state, DDC_PWR_ON);
      $display("power test done");
      cmd(1'b1, 1'b0, 1'b1, 3'h4, 2'h0, 2'h0, 14'h0000);
      beat(8'h55, 1'b1, 1'b1, 8'h55);
      beat(8'haa, 1'b0, 1'b0, 8'h00);
      @(posedge i_mclk);
      i_mr5_dm_en <= 1'b0;
      i_mr5_wdbi_en <= 1'b1;
      beat(8'h0f, 1'b0, 1'b1, 8'hf0);
      beat(8'h3c, 1'b1, 1'b1, 8'h3c);
      beat(8'h11, 1'b1, 1'b0, 8'h00);
      cmd(1'b1, 1'b0, 1'b0, 3'h0, 2'h0, 2'h0, 14'h0000);
      chk(o_bank_open, 16'h0001);
      cmd(1'b1, 1'b0, 1'b1, 3'h4, 2'h0, 2'h0, 14'h1523);
      chk({o_auto_pre, o_burst_chop, o_col, o_bank_open}, 28'h9230000);
      ddc_host_inst.refresh();
      #1;
      chk({o_cmd_valid, o_cmd}, {1'b1, DDC_CMD_REF});
      $display("write test done");
      for (int j = 0; j < 2; j++)
      begin
         @(posedge i_mclk);
         i_cl <= j ? 5'h16 : 5'h0e;
         len = j ? 4 : 8;
         lat = j ? 22 : 14;
         cmd(1'b1, 1'b0, 1'b1, 3'h5, 2'h0, 2'h0, j ? 14'h0000 : 14'h1000);
         chk({o_auto_pre, o_burst_chop}, j ? 2'h1 : 2'h0);
         for (int n = 1; n <= lat + len; n++)
         begin
            tick(1);
            chk(o_rd_valid, n >= lat && n < lat + len);
            if (n >= lat && n < lat + len)
               chk({o_rd_dq, o_rd_dbi_n}, 9'h1fe);
         end
      end
      $display("read test done");
      @(posedge i_mclk);
      i_odt <= 1'b1;
      i_tdqs_en <= 1'b1;
      tick(3);
      chk({o_odt_term, o_tdqs_term}, 2'h3);
      @(posedge i_mclk);
      i_rtt_nom_en <= 1'b0;
      tick(3);
      chk(o_odt_term, 1'b0);
      $display("termination test done");
      cmd(1'b1, 1'b0, 1'b0, 3'h0, 2'h1, 2'h3, 14'h0000);
      chk(o_bank_open, 16'h0080);
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      tick(1);
      chk({o_cmd_valid, o_bank_open, o_rd_dbi_n, o_int_clk_en}, 19'h00002);
      @(posedge i_mclk);
      i_rst_n <= 1'b1;
      tick(3);
      cmd(1'b1, 1'b0, 1'b1, 3'h0, 2'h0, 2'h0, 14'h0000);
      chk({o_cmd_valid, o_int_clk_en}, 2'h3);
      $display("mid-run reset test done");
      complete_run();
   end
endmodule : ddc_front_bench
